// ==== inc/mqps_pkg.sv ====
// Shared constants, modes and carrier types of the multi-queue port select block
package mqps_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int unsigned MQPS_DATA_W = 36;
  localparam int unsigned MQPS_QUEUES = 8;
  localparam int unsigned MQPS_QSEL_W = 3;
  localparam int unsigned MQPS_QDEPTH = 512;
  localparam int unsigned MQPS_PTR_W = 9;
  localparam int unsigned MQPS_CNT_W = 10;
  localparam int unsigned MQPS_ADDR_W = 8;
  localparam int unsigned MQPS_ID_W = 3;
  localparam int unsigned MQPS_ID_LSB = 5;
  localparam int unsigned MQPS_FIFO_DEPTH = 16;

  // ********************************************************************
  // Counts and thresholds
  // ********************************************************************
  localparam logic [2:0] MQPS_CFG_SETTLE = 3'h6;
  localparam logic [9:0] MQPS_AE_OFFSET = 10'h008;
  localparam logic [9:0] MQPS_PKT_MIN_WORDS = 10'h004;

  // ********************************************************************
  // Modes and states
  // ********************************************************************
  typedef enum logic [1:0] {
    MQPS_WORD_STD = 2'b00,
    MQPS_WORD_FALL = 2'b01,
    MQPS_PKT_STD = 2'b10,
    MQPS_PKT_FALL = 2'b11
  } mqps_mode_t;

  typedef enum logic [1:0] {
    MQPS_SW_IDLE = 2'b00,
    MQPS_SW_SEL = 2'b01,
    MQPS_SW_WAIT = 2'b10
  } mqps_sw_t;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic clk;
    logic strobe;
    logic wen_n;
    logic [MQPS_ADDR_W-1:0] addr;
    logic [MQPS_DATA_W-1:0] data;
  } mqps_wr_in_t;

  typedef struct packed {
    logic clk;
    logic strobe;
    logic ren_n;
    logic oe_n;
    logic [MQPS_ADDR_W-1:0] addr;
  } mqps_rd_in_t;

  typedef struct packed {
    logic pkt;
    logic fall;
    logic [MQPS_ID_W-1:0] id;
  } mqps_cfg_in_t;

  typedef struct packed {
    logic [MQPS_QSEL_W-1:0] q;
    logic [MQPS_DATA_W-1:0] data;
  } mqps_fifo_word_t;

  localparam mqps_wr_in_t MQPS_WR_IN_RST = '{clk: 1'b0, strobe: 1'b0, wen_n: 1'b1,
                                             addr: '0, data: '0};
  localparam mqps_rd_in_t MQPS_RD_IN_RST = '{clk: 1'b0, strobe: 1'b0, ren_n: 1'b1,
                                             oe_n: 1'b1, addr: '0};
  localparam mqps_cfg_in_t MQPS_CFG_IN_RST = '{pkt: 1'b0, fall: 1'b0, id: '0};

endpackage

// ==== rtl/mqps_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module mqps_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pin side and filtered side
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  // Stage chain; the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit only moves once the second and third stage agree
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_q <= RST;
    end else begin
      q_q <= (s3_q & ~(s2_q ^ s3_q)) | (q_q & (s2_q ^ s3_q));
    end
  end

  assign q = q_q;
endmodule
`default_nettype wire

// ==== rtl/mqps_fifo.sv ====
// Small valid/ready FIFO for the write data path
`timescale 1ns/10ps
`default_nettype none
module mqps_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_q[AW-1:0]];

  // Storage has no reset; only pointers decide what is valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + (AW+1)'(1);
      end
      if (pop) begin
        rp_q <= rp_q + (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/mqps_top.sv ====
// Eight-queue buffer with pin-selected write and read queues
`timescale 1ns/10ps
`default_nettype none
module mqps_top import mqps_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Static configuration pins
  input wire logic packet_mode_pin,
  input wire logic fall_through_pin,
  input wire logic [MQPS_ID_W-1:0] chip_identity_pins,
  // Write port
  input wire logic write_clk_pin,
  input wire logic write_addr_strobe,
  input wire logic write_en_n,
  input wire logic [MQPS_ADDR_W-1:0] write_queue_addr,
  input wire logic [MQPS_DATA_W-1:0] write_data,
  output logic write_port_flag_n,
  // Read port
  input wire logic read_clk_pin,
  input wire logic read_addr_strobe,
  input wire logic read_en_n,
  input wire logic out_en_n,
  input wire logic [MQPS_ADDR_W-1:0] read_queue_addr,
  output logic [MQPS_DATA_W-1:0] read_data,
  output logic read_data_oe_n,
  output logic read_port_flag_n,
  // Queue status
  output logic [MQPS_QUEUES-1:0] almost_empty_n,
  output logic packet_valid
);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  mqps_wr_in_t wr_pins;
  mqps_wr_in_t wr_in;
  mqps_rd_in_t rd_pins;
  mqps_rd_in_t rd_in;
  mqps_cfg_in_t cfg_pins;
  mqps_cfg_in_t cfg_in;

  // Each port's clock travels with its data so edge and data stay aligned
  assign wr_pins = '{clk: write_clk_pin, strobe: write_addr_strobe, wen_n: write_en_n,
                     addr: write_queue_addr, data: write_data};
  assign rd_pins = '{clk: read_clk_pin, strobe: read_addr_strobe, ren_n: read_en_n,
                     oe_n: out_en_n, addr: read_queue_addr};
  assign cfg_pins = '{pkt: packet_mode_pin, fall: fall_through_pin, id: chip_identity_pins};

  mqps_sync #(.W($bits(mqps_wr_in_t)), .RST(MQPS_WR_IN_RST)) u_wr_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(wr_pins),
    .q(wr_in)
  );

  mqps_sync #(.W($bits(mqps_rd_in_t)), .RST(MQPS_RD_IN_RST)) u_rd_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(rd_pins),
    .q(rd_in)
  );

  mqps_sync #(.W($bits(mqps_cfg_in_t)), .RST(MQPS_CFG_IN_RST)) u_cfg_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(cfg_pins),
    .q(cfg_in)
  );

  // ********************************************************************
  // Configuration straps
  // ********************************************************************
  mqps_mode_t mode_q;
  logic [MQPS_ID_W-1:0] id_q;
  logic [2:0] cfg_cnt_q;
  logic cfg_done;
  logic fall;
  logic pkt;

  assign cfg_done = (cfg_cnt_q == MQPS_CFG_SETTLE);
  assign pkt = mode_q[1];
  assign fall = mode_q[0];

  // Straps follow the pins only until the synchroniser has settled, then freeze
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MQPS_WORD_STD;
      id_q <= '0;
      cfg_cnt_q <= '0;
    end else if (!cfg_done) begin
      mode_q <= mqps_mode_t'({cfg_in.pkt, cfg_in.fall});
      id_q <= cfg_in.id;
      cfg_cnt_q <= cfg_cnt_q + 3'h1;
    end
  end

  // ********************************************************************
  // Shared helpers
  // ********************************************************************
  // Chip match on the upper address bits
  function automatic logic mqps_hit(input logic [MQPS_ADDR_W-1:0] a,
                                    input logic [MQPS_ID_W-1:0] id);
    mqps_hit = (a[MQPS_ADDR_W-1:MQPS_ID_LSB] == id);
  endfunction

  // Occupancy step, one up and one down in the same cycle cancel
  function automatic logic [MQPS_CNT_W-1:0] mqps_step(input logic [MQPS_CNT_W-1:0] c,
                                                      input logic inc, input logic dec);
    mqps_step = c + {{(MQPS_CNT_W-1){1'b0}}, inc} - {{(MQPS_CNT_W-1){1'b0}}, dec};
  endfunction

  // ********************************************************************
  // Write port queue selection
  // ********************************************************************
  logic wclk_last_q;
  logic wr_edge;
  logic wsel_hit;
  mqps_sw_t wsw_q;
  logic [MQPS_QSEL_W-1:0] wr_pend_q;
  logic [MQPS_QSEL_W-1:0] wr_act_q;

  assign wr_edge = wr_in.clk && !wclk_last_q;
  assign wsel_hit = wr_edge && wr_in.strobe && mqps_hit(wr_in.addr, id_q);

  // Write clock edge detect
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wclk_last_q <= 1'b0;
    end else begin
      wclk_last_q <= wr_in.clk;
    end
  end

  // Capture edge, one hold edge, then switch on the third; a new capture restarts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wsw_q <= MQPS_SW_IDLE;
      wr_pend_q <= '0;
      wr_act_q <= '0;
    end else if (wsel_hit) begin
      wsw_q <= MQPS_SW_SEL;
      wr_pend_q <= wr_in.addr[MQPS_QSEL_W-1:0];
    end else if (wr_edge) begin
      case (wsw_q)
        MQPS_SW_IDLE: begin
          wsw_q <= MQPS_SW_IDLE;
        end
        MQPS_SW_SEL: begin
          wsw_q <= MQPS_SW_WAIT;
        end
        MQPS_SW_WAIT: begin
          wsw_q <= MQPS_SW_IDLE;
          wr_act_q <= wr_pend_q;
        end
        default: begin
          wsw_q <= MQPS_SW_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // Read port queue selection
  // ********************************************************************
  logic rclk_last_q;
  logic rd_edge;
  logic rsel_hit;
  mqps_sw_t rsw_q;
  logic [MQPS_QSEL_W-1:0] rd_pend_q;
  logic [MQPS_QSEL_W-1:0] rd_act_q;

  assign rd_edge = rd_in.clk && !rclk_last_q;
  assign rsel_hit = rd_edge && rd_in.strobe && mqps_hit(rd_in.addr, id_q);

  // Read clock edge detect
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rclk_last_q <= 1'b0;
    end else begin
      rclk_last_q <= rd_in.clk;
    end
  end

  // Same sequence as the write side, on read clock edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsw_q <= MQPS_SW_IDLE;
      rd_pend_q <= '0;
      rd_act_q <= '0;
    end else if (rsel_hit) begin
      rsw_q <= MQPS_SW_SEL;
      rd_pend_q <= rd_in.addr[MQPS_QSEL_W-1:0];
    end else if (rd_edge) begin
      case (rsw_q)
        MQPS_SW_IDLE: begin
          rsw_q <= MQPS_SW_IDLE;
        end
        MQPS_SW_SEL: begin
          rsw_q <= MQPS_SW_WAIT;
        end
        MQPS_SW_WAIT: begin
          rsw_q <= MQPS_SW_IDLE;
          rd_act_q <= rd_pend_q;
        end
        default: begin
          rsw_q <= MQPS_SW_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // Occupancy and flags
  // ********************************************************************
  logic [MQPS_CNT_W-1:0] cnt_res_q [MQPS_QUEUES];
  logic [MQPS_CNT_W-1:0] cnt_com_q [MQPS_QUEUES];
  logic wq_full;
  logic wq_block;
  logic rq_empty;
  logic wr_accept;
  logic rd_fire;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic drain;
  mqps_fifo_word_t fifo_in;
  mqps_fifo_word_t fifo_out;

  // Full counts words still in the path FIFO, so the flag never overbooks a queue
  assign wq_full = (cnt_res_q[wr_act_q] == MQPS_CNT_W'(MQPS_QDEPTH));
  assign wq_block = wq_full || !fifo_in_ready;
  assign rq_empty = (cnt_com_q[rd_act_q] == '0);
  assign write_port_flag_n = fall ? wq_block : !wq_block;
  assign read_port_flag_n = fall ? rq_empty : !rq_empty;

  // Transfers happen on enable-low edges whatever the selection state
  assign wr_accept = wr_edge && !wr_in.wen_n && !wq_block;
  assign rd_fire = rd_edge && !rd_in.ren_n && !rq_empty;

  // Reserved and committed occupancy per queue
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MQPS_QUEUES; i++) begin
        cnt_res_q[i] <= '0;
        cnt_com_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < MQPS_QUEUES; i++) begin
        cnt_res_q[i] <= mqps_step(cnt_res_q[i], wr_accept && (wr_act_q == i),
                                  rd_fire && (rd_act_q == i));
        cnt_com_q[i] <= mqps_step(cnt_com_q[i], drain && (fifo_out.q == i),
                                  rd_fire && (rd_act_q == i));
      end
    end
  end

  // ********************************************************************
  // Write data path
  // ********************************************************************
  assign fifo_in = '{q: wr_act_q, data: wr_in.data};
  // Memory has one port; a read steals the cycle and the FIFO absorbs the stall
  assign fifo_out_ready = !rd_fire;
  assign drain = fifo_out_valid && fifo_out_ready;

  mqps_fifo #(.W($bits(mqps_fifo_word_t)), .DEPTH(MQPS_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(wr_accept),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // ********************************************************************
  // Queue memory
  // ********************************************************************
  logic [MQPS_DATA_W-1:0] qmem [MQPS_QUEUES*MQPS_QDEPTH];
  logic [MQPS_PTR_W-1:0] wptr_q [MQPS_QUEUES];
  logic [MQPS_PTR_W-1:0] rptr_q [MQPS_QUEUES];
  logic [MQPS_DATA_W-1:0] read_data_q;

  // Queue memory writes from the head of the path FIFO
  always_ff @(posedge clk_sys) begin
    if (drain) begin
      qmem[{fifo_out.q, wptr_q[fifo_out.q]}] <= fifo_out.data;
    end
  end

  // Output register loads even with the bus parked
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      read_data_q <= '0;
    end else if (rd_fire) begin
      read_data_q <= qmem[{rd_act_q, rptr_q[rd_act_q]}];
    end
  end

  // Per-queue pointers wrap at the queue depth
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MQPS_QUEUES; i++) begin
        wptr_q[i] <= '0;
        rptr_q[i] <= '0;
      end
    end else begin
      if (drain) begin
        wptr_q[fifo_out.q] <= wptr_q[fifo_out.q] + MQPS_PTR_W'(1);
      end
      if (rd_fire) begin
        rptr_q[rd_act_q] <= rptr_q[rd_act_q] + MQPS_PTR_W'(1);
      end
    end
  end

  assign read_data = read_data_q;
  assign read_data_oe_n = rd_in.oe_n;

  // ********************************************************************
  // Queue status bus
  // ********************************************************************
  logic [MQPS_QUEUES-1:0] ae_n_q;

  // Almost empty in word mode, packet ready in packet mode; both active low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ae_n_q <= '0;
    end else begin
      for (int i = 0; i < MQPS_QUEUES; i++) begin
        ae_n_q[i] <= pkt ? !(cnt_com_q[i] >= MQPS_PKT_MIN_WORDS)
                         : !(cnt_com_q[i] <= MQPS_AE_OFFSET);
      end
    end
  end

  assign almost_empty_n = ae_n_q;
  assign packet_valid = pkt && !ae_n_q[rd_act_q] && !rq_empty;

  // ********************************************************************
  // Checks
  // ********************************************************************
  mode_frozen_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfg_done |=> $stable(mode_q) && $stable(id_q))
    else $error("mode changed after settling");

  wr_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wq_full |-> (write_port_flag_n == fall))
    else $error("write flag wrong for full queue");

  rd_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rq_empty |-> (read_port_flag_n == fall) && !packet_valid)
    else $error("read flag wrong for empty queue");

  wr_store_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(cnt_res_q[wr_act_q]) && !$past(rd_fire) |-> $past(wr_accept) ||
      $past(wr_act_q) != wr_act_q)
    else $error("store without write enable");

  wr_take_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_edge && !wr_in.wen_n && !wq_full && fifo_in_ready && !rd_fire
      |=> cnt_res_q[$past(wr_act_q)] == $past(cnt_res_q[wr_act_q]) + 10'h001)
    else $error("enabled write not taken");

  wr_switch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(wr_act_q) |-> $past(wr_edge) && $past(wsw_q) == MQPS_SW_WAIT &&
      !$past(wsel_hit))
    else $error("write queue switched early");

  rd_switch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(rd_act_q) |-> $past(rd_edge) && $past(rsw_q) == MQPS_SW_WAIT)
    else $error("read queue switched early");

  wr_select_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(wr_pend_q) |-> $past(wr_edge && wr_in.strobe) &&
      $past(wr_in.addr[MQPS_ADDR_W-1:MQPS_ID_LSB]) == id_q)
    else $error("write selection without chip match");

  rd_select_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(rd_pend_q) |-> $past(rd_edge && rd_in.strobe))
    else $error("read selection without strobe");

  // Pointer of the active read queue, kept so a blocked read is judged across a switch
  logic [MQPS_PTR_W-1:0] rptr_sel;
  assign rptr_sel = rptr_q[rd_act_q];

  rd_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_edge && (rq_empty || rd_in.ren_n) |=> $stable(read_data_q) &&
      rptr_q[$past(rd_act_q)] == $past(rptr_sel))
    else $error("read advanced while blocked");

endmodule
`default_nettype wire

// ==== bench/mqps_host.sv ====
// Host logic model that drives the write and read port pins
`timescale 1ns/10ps
`default_nettype none
module mqps_host import mqps_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Write port pins
  output logic wclk,
  output logic wstb,
  output logic wen_n,
  output logic [MQPS_ADDR_W-1:0] waddr,
  output logic [MQPS_DATA_W-1:0] wdata,
  // Read port pins
  output logic rclk,
  output logic rstb,
  output logic ren_n,
  output logic [MQPS_ADDR_W-1:0] raddr
);
  // Idle pins at time zero
  initial begin
    {wclk, wstb, rclk, rstb} = 4'h0;
    {wen_n, ren_n} = 2'h3;
    waddr = '0;
    raddr = '0;
    wdata = '0;
  end
  // One slow write clock; pins must stay high and low for several system clocks
  task automatic wcyc(input logic s, input logic e, input logic [MQPS_ADDR_W-1:0] a,
                      input logic [MQPS_DATA_W-1:0] d);
    @(negedge clk_sys);
    wstb = s;
    wen_n = e;
    waddr = a;
    wdata = d;
    repeat (2) @(negedge clk_sys);
    wclk = 1'b1;
    repeat (6) @(negedge clk_sys);
    wclk = 1'b0;
    wstb = 1'b0;
    wen_n = 1'b1;
    wdata = ~d; // Released bus shows no stale word
    repeat (6) @(negedge clk_sys);
  endtask
  // One slow read clock
  task automatic rcyc(input logic s, input logic e, input logic [MQPS_ADDR_W-1:0] a);
    @(negedge clk_sys);
    rstb = s;
    ren_n = e;
    raddr = a;
    repeat (2) @(negedge clk_sys);
    rclk = 1'b1;
    repeat (6) @(negedge clk_sys);
    rclk = 1'b0;
    rstb = 1'b0;
    ren_n = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== bench/mqps_top_tb.sv ====
// Self-checking testbench of the multi-queue port select block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module mqps_top_tb import mqps_pkg::*; ;
  logic clk_sys;
  logic nrst;
  logic fall;
  logic pkt;
  logic [MQPS_ID_W-1:0] id;
  logic out_en_n;
  logic wclk, wstb, wen_n, rclk, rstb, ren_n;
  logic [MQPS_ADDR_W-1:0] waddr, raddr;
  logic [MQPS_DATA_W-1:0] wdata, rdata;
  logic wflag, rflag, oe_q, pv;
  logic [MQPS_QUEUES-1:0] ae_n;
  int miscompares = 0;
  int compares = 0;

  mqps_host host (.clk_sys(clk_sys), .wclk(wclk), .wstb(wstb), .wen_n(wen_n),
    .waddr(waddr), .wdata(wdata), .rclk(rclk), .rstb(rstb), .ren_n(ren_n), .raddr(raddr));
  mqps_top uut (.clk_sys(clk_sys), .nrst(nrst), .packet_mode_pin(pkt),
    .fall_through_pin(fall), .chip_identity_pins(id), .write_clk_pin(wclk),
    .write_addr_strobe(wstb), .write_en_n(wen_n), .write_queue_addr(waddr),
    .write_data(wdata), .write_port_flag_n(wflag), .read_clk_pin(rclk),
    .read_addr_strobe(rstb), .read_en_n(ren_n), .out_en_n(out_en_n),
    .read_queue_addr(raddr), .read_data(rdata), .read_data_oe_n(oe_q),
    .read_port_flag_n(rflag), .almost_empty_n(ae_n), .packet_valid(pv));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("Compares %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Straps are caught right after release, so a mode change needs a new reset
  task automatic do_reset(input logic f);
    nrst = 1'b0;
    fall = f;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask

  task automatic t_reset();
    `CHK("rflag", 1'b0, rflag)
    `CHK("wflag", 1'b1, wflag)
    `CHK("rdata", 36'h0, rdata)
    `CHK("ae_n", 8'h00, ae_n)
    `CHK("pv", 1'b0, pv)
    $display("t_reset done");
  endtask

  // One word kept, one dropped; output enable held off meanwhile
  task automatic t_word();
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h123456789);
    host.wcyc(1'b0, 1'b1, 8'h00, 36'hABCDEF012);
    `CHK("rflag", 1'b1, rflag)
    host.rcyc(1'b0, 1'b0, 8'h00);
    `CHK("rdata", 36'h123456789, rdata)
    `CHK("rflag", 1'b0, rflag)
    host.rcyc(1'b0, 1'b0, 8'h00);
    `CHK("rdata", 36'h123456789, rdata)
    `CHK("oe", 1'b1, oe_q)
    out_en_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    `CHK("oe", 1'b0, oe_q)
    $display("t_word done");
  endtask

  // Write switch to queue 2, then read switch with a foreign chip select first
  task automatic t_switch();
    host.wcyc(1'b1, 1'b0, 8'h02, 36'h0000000A1);
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h0000000B2);
    host.wcyc(1'b0, 1'b1, 8'h00, 36'h0);
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h0000000C3);
    host.rcyc(1'b0, 1'b0, 8'h00);
    `CHK("rdata", 36'h0000000A1, rdata)
    host.rcyc(1'b1, 1'b0, 8'h22);
    `CHK("rdata", 36'h0000000B2, rdata)
    repeat (2) host.rcyc(1'b0, 1'b1, 8'h00);
    `CHK("rflag", 1'b0, rflag)
    host.rcyc(1'b1, 1'b1, 8'h02);
    `CHK("rflag", 1'b0, rflag)
    repeat (2) host.rcyc(1'b0, 1'b1, 8'h00);
    `CHK("rflag", 1'b1, rflag)
    host.rcyc(1'b0, 1'b0, 8'h00);
    `CHK("rdata", 36'h0000000C3, rdata)
    $display("t_switch done");
  endtask

  // Fill queue 2 to the brim, try one more, then drain it
  task automatic t_full();
    for (int i = 0; i < MQPS_QDEPTH; i++) begin
      host.wcyc(1'b0, 1'b0, 8'h00, 36'(i));
      if (i == MQPS_QDEPTH - 2) `CHK("wflag", 1'b1, wflag)
    end
    `CHK("wflag", 1'b0, wflag)
    `CHK("ae_n", 8'h04, ae_n)
    host.wcyc(1'b0, 1'b0, 8'h00, 36'hFFFFFFFFF);
    repeat (MQPS_QDEPTH) host.rcyc(1'b0, 1'b0, 8'h00);
    `CHK("rdata", 36'(MQPS_QDEPTH - 1), rdata)
    `CHK("rflag", 1'b0, rflag)
    `CHK("wflag", 1'b1, wflag)
    $display("t_full done");
  endtask

  task automatic t_fall();
    do_reset(1'b1);
    `CHK("rflag", 1'b1, rflag)
    `CHK("wflag", 1'b0, wflag)
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h000000055);
    `CHK("rflag", 1'b0, rflag)
    fall = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("rflag", 1'b0, rflag)
    $display("t_fall done");
  endtask

  // Packet mode on chip one; a selection for chip zero must be ignored
  task automatic t_pkt();
    pkt = 1'b1;
    id = 3'h1;
    do_reset(1'b1);
    `CHK("ae_n", 8'hFF, ae_n)
    host.wcyc(1'b1, 1'b0, 8'h01, 36'h000000001);
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h000000002);
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h000000003);
    `CHK("pv", 1'b0, pv)
    host.wcyc(1'b0, 1'b0, 8'h00, 36'h000000004);
    `CHK("ae_n", 8'hFE, ae_n)
    `CHK("pv", 1'b1, pv)
    `CHK("rflag", 1'b0, rflag)
    host.rcyc(1'b0, 1'b0, 8'h00);
    `CHK("rdata", 36'h000000001, rdata)
    `CHK("ae_n", 8'hFF, ae_n)
    `CHK("pv", 1'b0, pv)
    $display("t_pkt done");
  endtask

  // Watchdog well beyond the roughly 16000 cycles of the tests
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end

  initial begin
    out_en_n = 1'b1;
    pkt = 1'b0;
    id = 3'h0;
    do_reset(1'b0);
    t_reset();
    t_word();
    t_switch();
    t_full();
    t_fall();
    t_pkt();
    finish_test();
  end
endmodule
`default_nettype wire
